//--- rtl/mqf_pkg.sv
// Purpose: Shared constants and types for the multi-queue flag block.
// Assumes: Four queues per device, 6-bit queue addresses, 9-bit storage units.
// Notes: Register offsets are byte addresses on the plain register port.
package mqf_pkg;

  localparam int NQ = 4;
  localparam int QIDX_W = 2;
  localparam int ID_W = 3;
  localparam int REG_AW = 4;
  localparam int IRQ_W = 3;

  // Register map, one 32-bit word per register.
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] REG_STAT = 4'h4;
  localparam logic [REG_AW-1:0] REG_IRQ_ST = 4'h8;
  localparam logic [REG_AW-1:0] REG_IRQ_MSK = 4'hC;

  // Control fields: a set bit selects the narrow 9-bit port width.
  localparam int CTRL_IW_BIT = 0;
  localparam int CTRL_OW_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Status layout: full vector in the low nibble, word-ready vector above it.
  localparam int STAT_READY_LSB = 4;

  // Interrupt events.
  localparam int IRQ_WR_REFUSED = 0;
  localparam int IRQ_OV_INVALID = 1;
  localparam int IRQ_RD_SWITCH = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // Storage units moved per transfer for each port width.
  localparam logic [1:0] UNITS_WIDE = 2'h2;
  localparam logic [1:0] UNITS_NARROW = 2'h1;

  // Queue address as it appears on both port address buses.
  typedef struct packed {
    logic [ID_W-1:0] dev;
    logic null_q;
    logic [QIDX_W-1:0] queue;
  } mqf_qaddr_t;

  // Read-side queue switch progress.
  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT,
    SW_LOAD
  } mqf_sw_t;

  function automatic logic [1:0] mqf_units(input logic narrow);
    mqf_units = narrow ? UNITS_NARROW : UNITS_WIDE;
  endfunction

  function automatic logic mqf_id_match(input mqf_qaddr_t a, input logic [ID_W-1:0] id);
    mqf_id_match = (a.dev == id);
  endfunction

endpackage

//--- rtl/mqf_occ.sv
// Purpose: Occupancy counter of one queue, counted in 9-bit storage units.
// Assumes: Push and pop never exceed the stored or free amount.
// Notes: Full uses write units, word-ready uses read units.
`timescale 1ns/100ps
`default_nettype none
module mqf_occ #(
  parameter int DEPTH_UNITS = 16384
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PUSH,
  input wire logic POP,
  input wire logic [1:0] WR_UNITS,
  input wire logic [1:0] RD_UNITS,
  output logic FULL,
  output logic WORD_READY
);
  import mqf_pkg::*;

  localparam int CW = $clog2(DEPTH_UNITS + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH_UNITS);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Push and pop in one cycle both apply, so a shared queue stays exact.
  always_comb begin
    cnt_d = cnt_q;
    if (PUSH) begin
      cnt_d = cnt_d + CW'(WR_UNITS);
    end
    if (POP) begin
      cnt_d = cnt_d - CW'(RD_UNITS);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Full when a whole write word no longer fits.
  assign FULL = (DEPTH_C - cnt_q) < CW'(WR_UNITS);
  assign WORD_READY = cnt_q >= CW'(RD_UNITS);

endmodule
`default_nettype wire

//--- rtl/mqf_flags.sv
// Purpose: Active-queue full flag and output-valid flag of a four-queue device.
// Assumes: Controller signals are synchronous to CORE_CLK; ID pins are static.
// Notes: Flags are active low and tri-stated by an output enable per flag.
//
// Summary of operation
// - Keep full per queue, show selected one.
// - Full flag shows new queue next edge.
// - First write allowed second edge after selection.
// - Full flag changes only on clock edges.
// - Reads update full status of any queue.
// - Drive full flag only on ID match.
// - Same-device switches keep driving full flag.
// - Output load edge also updates valid flag.
// - Valid goes high after last word read.
// - New queue word and valid two cycles later.
// - Valid flag changes only on clock edges.
// - Writes mark any queue not empty.
// - Drive valid flag only on ID match.
// - Same-device switches keep driving valid flag.
// - Null read queue behaves as empty queue.
// - Full counts write width, valid read width.
// - Full low when full, valid low when valid.
`timescale 1ns/100ps
`default_nettype none
module mqf_flags #(
  parameter int DEPTH_UNITS = 16384
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire mqf_pkg::mqf_qaddr_t WRITE_QUEUE_ADDR,
  input wire logic WRITE_ADDR_STROBE,
  input wire logic WRITE_EN_N,
  input wire mqf_pkg::mqf_qaddr_t READ_QUEUE_ADDR,
  input wire logic READ_ADDR_STROBE,
  input wire logic READ_EN_N,
  input wire logic DEVICE_ID_BIT0,
  input wire logic DEVICE_ID_BIT1,
  input wire logic DEVICE_ID_BIT2,
  input wire logic [mqf_pkg::REG_AW-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic IRQ,
  output logic ACTIVE_QUEUE_FULL_N_O,
  output logic ACTIVE_QUEUE_FULL_N_OE,
  output logic OUTPUT_WORD_VALID_N_O,
  output logic OUTPUT_WORD_VALID_N_OE
);
  import mqf_pkg::*;

  // After reset no read queue has been used, so the old source counts as the null queue.
  localparam mqf_qaddr_t NO_SRC_QADDR = '{dev: '0, null_q: 1'b1, queue: '0};

  logic [ID_W-1:0] id_s1_q;
  logic [ID_W-1:0] id_q;
  logic [1:0] ctrl_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_msk_q;
  logic [IRQ_W-1:0] irq_set;
  logic [31:0] rdata_q;
  logic [QIDX_W-1:0] wq_q;
  logic wr_match_q;
  logic fresh_q;
  logic ff_n_q;
  logic ff_oe_q;
  logic [NQ-1:0] full_vec;
  logic [NQ-1:0] ready_vec;
  logic [NQ-1:0] push_vec;
  logic [NQ-1:0] pop_vec;
  logic wr_ok;
  logic wr_refused;
  logic [1:0] wr_units;
  logic [1:0] rd_units;
  mqf_sw_t sw_q;
  mqf_qaddr_t new_q;
  mqf_qaddr_t src_q;
  mqf_qaddr_t cur_src;
  logic rd_match_q;
  logic out_full_q;
  logic ov_n_q;
  logic ov_oe_q;
  logic load;
  logic src_avail;

  // ID straps pass two flops; only the second stage is read.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      id_s1_q <= '0;
      id_q <= '0;
    end else begin
      id_s1_q <= {DEVICE_ID_BIT2, DEVICE_ID_BIT1, DEVICE_ID_BIT0};
      id_q <= id_s1_q;
    end
  end

  assign wr_units = mqf_units(ctrl_q[CTRL_IW_BIT]);
  assign rd_units = mqf_units(ctrl_q[CTRL_OW_BIT]);

  // One occupancy counter per queue, all tracked regardless of selection.
  for (genvar g = 0; g < NQ; g++) begin : g_q
    mqf_occ #(
      .DEPTH_UNITS(DEPTH_UNITS)
    ) u_occ (
      .CORE_CLK(CORE_CLK),
      .RST_N(RST_N),
      .PUSH(push_vec[g]),
      .POP(pop_vec[g]),
      .WR_UNITS(wr_units),
      .RD_UNITS(rd_units),
      .FULL(full_vec[g]),
      .WORD_READY(ready_vec[g])
    );
  end

  // Write selection; the device match decides who owns the shared flag.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wq_q <= '0;
      wr_match_q <= 1'b0;
      fresh_q <= 1'b0;
    end else begin
      fresh_q <= WRITE_ADDR_STROBE;
      if (WRITE_ADDR_STROBE) begin
        wq_q <= WRITE_QUEUE_ADDR.queue;
        wr_match_q <= mqf_id_match(WRITE_QUEUE_ADDR, id_q);
      end
    end
  end

  // A write in the cycle right after selection is ignored, as is one into a full queue.
  assign wr_ok = !WRITE_EN_N && wr_match_q && !fresh_q && !full_vec[wq_q];
  assign wr_refused = !WRITE_EN_N && wr_match_q && !fresh_q && full_vec[wq_q];
  assign push_vec = wr_ok ? (NQ'(1) << wq_q) : '0;

  // Full flag is a registered view of the selected queue, one edge behind the select.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ff_n_q <= 1'b1;
      ff_oe_q <= 1'b0;
    end else begin
      ff_n_q <= !full_vec[wq_q];
      ff_oe_q <= wr_match_q;
    end
  end

  assign ACTIVE_QUEUE_FULL_N_O = ff_n_q;
  assign ACTIVE_QUEUE_FULL_N_OE = ff_oe_q;

  // Read switch: one more load comes from the old queue before the new one takes over.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sw_q <= SW_IDLE;
      new_q <= '0;
      src_q <= NO_SRC_QADDR;
      rd_match_q <= 1'b0;
    end else begin
      if (READ_ADDR_STROBE) begin
        sw_q <= SW_WAIT;
        new_q <= READ_QUEUE_ADDR;
        rd_match_q <= mqf_id_match(READ_QUEUE_ADDR, id_q);
      end else begin
        case (sw_q)
          SW_WAIT: begin
            sw_q <= SW_LOAD;
          end
          SW_LOAD: begin
            sw_q <= SW_IDLE;
            src_q <= new_q;
          end
          default: begin
            sw_q <= SW_IDLE;
          end
        endcase
      end
    end
  end

  // Neither the null queue nor a queue of another device offers a word here.
  assign cur_src = (sw_q == SW_LOAD) ? new_q : src_q;
  assign src_avail = !cur_src.null_q && mqf_id_match(cur_src, id_q) &&
                     ready_vec[cur_src.queue];
  // The switch edge forces a load so the valid flag follows the new queue.
  assign load = rd_match_q && (!out_full_q || !READ_EN_N || (sw_q == SW_LOAD));
  assign pop_vec = (load && src_avail) ? (NQ'(1) << cur_src.queue) : '0;

  // Output register state; the load edge sets validity for the word it leaves.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_full_q <= 1'b0;
    end else if (load) begin
      out_full_q <= src_avail;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ov_n_q <= 1'b1;
      ov_oe_q <= 1'b0;
    end else begin
      if (load) begin
        ov_n_q <= !src_avail;
      end
      ov_oe_q <= rd_match_q;
    end
  end

  assign OUTPUT_WORD_VALID_N_O = ov_n_q;
  assign OUTPUT_WORD_VALID_N_OE = ov_oe_q;

  // Event sources for the interrupt status.
  assign irq_set[IRQ_WR_REFUSED] = wr_refused;
  assign irq_set[IRQ_OV_INVALID] = load && out_full_q && !src_avail;
  assign irq_set[IRQ_RD_SWITCH] = (sw_q == SW_LOAD) && !READ_ADDR_STROBE;

  // Control and mask registers written by software.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= CTRL_RST;
      irq_msk_q <= IRQ_RST;
    end else if (REG_WR) begin
      if (REG_ADDR == REG_CTRL) begin
        ctrl_q <= REG_WDATA[1:0];
      end
      if (REG_ADDR == REG_IRQ_MSK) begin
        irq_msk_q <= REG_WDATA[IRQ_W-1:0];
      end
    end
  end

  // Sticky status, write one to clear; a new event wins over its clear.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_st_q <= IRQ_RST;
    end else if (REG_WR && (REG_ADDR == REG_IRQ_ST)) begin
      irq_st_q <= (irq_st_q & ~REG_WDATA[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_st_q <= irq_st_q | irq_set;
    end
  end

  assign IRQ = |(irq_st_q & irq_msk_q);

  // Read data stands in the cycle after the strobe only; unmapped reads return zero.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= '0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        REG_CTRL: rdata_q <= {30'h0, ctrl_q};
        REG_STAT: rdata_q <= {24'h0, ready_vec, full_vec};
        REG_IRQ_ST: rdata_q <= {29'h0, irq_st_q};
        REG_IRQ_MSK: rdata_q <= {29'h0, irq_msk_q};
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign REG_RDATA = rdata_q;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  ff_switch_a: assert property (
    WRITE_ADDR_STROBE |=> ##1 (ff_n_q == !$past(full_vec[wq_q])))
    else $error("Full flag does not show the newly selected queue.");

  wr_gap_a: assert property (
    $past(WRITE_ADDR_STROBE) |-> !wr_ok)
    else $error("Write accepted one cycle after queue selection.");

  full_block_a: assert property (
    (!WRITE_EN_N && full_vec[wq_q]) |-> !push_vec[wq_q])
    else $error("Write accepted into a full queue.");

  ff_drive_a: assert property (
    WRITE_ADDR_STROBE |=> ##1
      (ff_oe_q == ($past(WRITE_QUEUE_ADDR.dev, 2) == $past(id_q, 2))))
    else $error("Full flag enable does not follow the device match.");

  ov_drive_a: assert property (
    READ_ADDR_STROBE |=> ##1
      (ov_oe_q == ($past(READ_QUEUE_ADDR.dev, 2) == $past(id_q, 2))))
    else $error("Valid flag enable does not follow the device match.");

  rd_switch_a: assert property (
    (READ_ADDR_STROBE ##1 !READ_ADDR_STROBE ##1 !READ_ADDR_STROBE) |=>
      (src_q == $past(new_q) && sw_q == SW_IDLE))
    else $error("Read queue switch did not complete two cycles later.");

  null_q_a: assert property (
    (sw_q == SW_LOAD && new_q.null_q && rd_match_q && !READ_ADDR_STROBE) |=> ov_n_q)
    else $error("Null queue selection left the valid flag low.");

  ov_last_a: assert property (
    (rd_match_q && out_full_q && !READ_EN_N && !src_avail) |=> (ov_n_q && !out_full_q))
    else $error("Valid flag stayed low after the last word was read.");

  irq_keep_a: assert property (
    (irq_set[IRQ_WR_REFUSED] && REG_WR && REG_ADDR == REG_IRQ_ST) |=>
      irq_st_q[IRQ_WR_REFUSED])
    else $error("Refused-write event lost against its clear.");

endmodule
`default_nettype wire

//--- tb/mqf_flag_bus.sv
// Purpose: Shared flag wires of an expansion bank, as the controller sees them.
// Assumes: At most one device drives each wire; the board pulls idle wires high.
// Notes: A released wire reads high, so a stale low never looks like full or valid.
`timescale 1ns/100ps
`default_nettype none
module mqf_flag_bus (
  input wire logic FULL_N_O,
  input wire logic FULL_N_OE,
  input wire logic VALID_N_O,
  input wire logic VALID_N_OE,
  output logic FULL_N_BUS,
  output logic VALID_N_BUS
);
  // Each shared wire carries the enabled driver's level or the pull-up level.
  assign FULL_N_BUS = FULL_N_OE ? FULL_N_O : 1'b1;
  assign VALID_N_BUS = VALID_N_OE ? VALID_N_O : 1'b1;
endmodule
`default_nettype wire

//--- tb/multiqueue_full_valid_flags_tb_top.sv
// Purpose: Self-checking bench for the full and output-valid flags.
// Assumes: Device ID straps tied to 3'h5; queues shortened to 8 units.
// Notes: Inputs change by non-blocking assignment at rising edges only.
`timescale 1ns/100ps
`default_nettype none
module multiqueue_full_valid_flags_tb_top;
  import mqf_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  mqf_qaddr_t waddr = '0;
  mqf_qaddr_t raddr = '0;
  logic wstb = 1'b0;
  logic rstb = 1'b0;
  logic wen_n = 1'b1;
  logic ren_n = 1'b1;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr_s = 1'b0;
  logic reg_rd_s = 1'b0;
  logic [31:0] reg_rdata;
  logic irq, full_o, full_oe, valid_o, valid_oe, full_bus, valid_bus;
  int fails = 0;
  int tests_run = 0;

  // A 100 ns clock matches the core rate.
  always #50 core_clk = ~core_clk;

  // Straps give ID 3'h5, so dev field 3'h5 selects this device.
  mqf_flags #(.DEPTH_UNITS(8)) i_mqf_flags (
    .CORE_CLK(core_clk), .RST_N(rst_n),
    .WRITE_QUEUE_ADDR(waddr), .WRITE_ADDR_STROBE(wstb), .WRITE_EN_N(wen_n),
    .READ_QUEUE_ADDR(raddr), .READ_ADDR_STROBE(rstb), .READ_EN_N(ren_n),
    .DEVICE_ID_BIT0(1'b1), .DEVICE_ID_BIT1(1'b0), .DEVICE_ID_BIT2(1'b1),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr_s), .REG_RD(reg_rd_s),
    .REG_RDATA(reg_rdata), .IRQ(irq),
    .ACTIVE_QUEUE_FULL_N_O(full_o), .ACTIVE_QUEUE_FULL_N_OE(full_oe),
    .OUTPUT_WORD_VALID_N_O(valid_o), .OUTPUT_WORD_VALID_N_OE(valid_oe)
  );

  mqf_flag_bus i_mqf_flag_bus (
    .FULL_N_O(full_o), .FULL_N_OE(full_oe), .VALID_N_O(valid_o), .VALID_N_OE(valid_oe),
    .FULL_N_BUS(full_bus), .VALID_N_BUS(valid_bus)
  );

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  // Let n edges pass, then look once their updates have settled.
  task automatic tick_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wsel(input logic [5:0] a);
    @(posedge core_clk);
    waddr <= mqf_qaddr_t'(a);
    wstb <= 1'b1;
    @(posedge core_clk);
    wstb <= 1'b0;
  endtask

  task automatic rsel(input logic [5:0] a);
    @(posedge core_clk);
    raddr <= mqf_qaddr_t'(a);
    rstb <= 1'b1;
    @(posedge core_clk);
    rstb <= 1'b0;
  endtask

  task automatic wr(input int n);
    repeat (n) begin
      @(posedge core_clk);
      wen_n <= 1'b0;
    end
    @(posedge core_clk);
    wen_n <= 1'b1;
  endtask

  task automatic rd(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ren_n <= 1'b0;
    end
    @(posedge core_clk);
    ren_n <= 1'b1;
  endtask

  task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_s <= 1'b1;
    @(posedge core_clk);
    reg_wr_s <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look right then.
  task automatic reg_rd(input logic [REG_AW-1:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd_s <= 1'b1;
    @(posedge core_clk);
    reg_rd_s <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hang is cut short and counted as a mismatch.
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    results();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    tick_n(3);
    chk("full_oe", 1'b0, full_oe);
    chk("valid_oe", 1'b0, valid_oe);
    reg_rd(REG_CTRL, 32'h0);
    $display("test reset done");
    // Fill queue 0 with four wide words, eight units.
    wsel(6'h28);
    tick_n(1);
    chk("full_oe", 1'b1, full_oe);
    chk("full_bus", 1'b1, full_bus);
    wr(4);
    tick_n(2);
    chk("full_bus", 1'b0, full_bus);
    reg_rd(REG_STAT, 32'h11);
    reg_rd(4'h2, 32'h0);
    wsel(6'h29);
    tick_n(1);
    chk("full_bus", 1'b1, full_bus);
    wsel(6'h28);
    tick_n(1);
    chk("full_bus", 1'b0, full_bus);
    $display("test write select done");
    // A write into the full queue is refused and raises a masked event.
    wr(1);
    tick_n(2);
    chk("irq", 1'b0, irq);
    reg_rd(REG_IRQ_ST, 32'h1);
    reg_wr(REG_IRQ_MSK, 32'h1);
    tick_n(1);
    chk("irq", 1'b1, irq);
    reg_wr(REG_IRQ_ST, 32'h1);
    tick_n(1);
    chk("irq", 1'b0, irq);
    $display("test interrupt done");
    // Read queue 0: the new word lands two edges after selection.
    rsel(6'h28);
    tick_n(1);
    chk("valid_oe", 1'b1, valid_oe);
    chk("valid_bus", 1'b1, valid_bus);
    tick_n(1);
    chk("valid_bus", 1'b0, valid_bus);
    rd(1);
    tick_n(2);
    chk("full_bus", 1'b1, full_bus);
    $display("test read select done");
    // An empty queue, then one word written while it is selected on the read port.
    rsel(6'h29);
    tick_n(2);
    chk("valid_bus", 1'b1, valid_bus);
    wsel(6'h29);
    tick_n(1);
    wr(1);
    tick_n(4);
    chk("valid_bus", 1'b0, valid_bus);
    rd(1);
    #1;
    chk("valid_bus", 1'b1, valid_bus);
    rsel(6'h28);
    tick_n(2);
    chk("valid_bus", 1'b0, valid_bus);
    rsel(6'h2C);
    tick_n(2);
    chk("valid_bus", 1'b1, valid_bus);
    $display("test fall through done");
    // Another device's address releases both flags.
    rsel(6'h10);
    tick_n(1);
    chk("valid_oe", 1'b0, valid_oe);
    wsel(6'h10);
    tick_n(1);
    chk("full_oe", 1'b0, full_oe);
    $display("test expansion done");
    // Switches and lost words left their sticky bits; the refused write was cleared.
    reg_rd(REG_IRQ_ST, 32'h6);
    reg_rd(REG_IRQ_MSK, 32'h1);
    // Narrow writes, wide reads: one write is half a read word.
    reg_wr(REG_CTRL, 32'h1);
    reg_rd(REG_CTRL, 32'h1);
    wsel(6'h2A);
    tick_n(1);
    chk("full_bus", 1'b1, full_bus);
    rsel(6'h2A);
    tick_n(2);
    chk("valid_bus", 1'b1, valid_bus);
    wr(1);
    tick_n(3);
    chk("valid_bus", 1'b1, valid_bus);
    wr(1);
    tick_n(2);
    chk("valid_bus", 1'b0, valid_bus);
    wr(7);
    tick_n(2);
    chk("full_bus", 1'b1, full_bus);
    wr(1);
    tick_n(2);
    chk("full_bus", 1'b0, full_bus);
    $display("test bus width done");
    results();
  end
endmodule
`default_nettype wire
